/* File: rtl/bias_defs.svh */
// Purpose: Constants of the bias supply supervisor: synchroniser bit map, timing, message codes.
// Assumes: A 100 MHz system clock.
// Notes: Definitions only; included by bare name.
`ifndef BIAS_DEFS_SVH
`define BIAS_DEFS_SVH

`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define BAUD_CNT_W 14
`define FRAME_BITS 10
`define QUEUE_DEPTH 8
`define MSG_W 8

`define CMP_PUMP_START 0
`define CMP_BUCK_IN_UV 1
`define CMP_CFG_LOST 2
`define CMP_VDD_UV 3
`define CMP_VDD_OV20 4
`define CMP_VDD_OV32 5
`define CMP_OV_STOP 6
`define CMP_BUCK_OCP 7
`define CMP_BUCK_BELOW90 8
`define CMP_BUCK_AT94 9
`define CMP_BUCK_BELOW80 10
`define CMP_FB_EXT 11
`define CMP_OTP_TRIP 12
`define CMP_OTP_COOL 13
`define CMP_THERM_WARN 14
`define CMP_CE 15
`define CMP_ILIM 16
`define CMP_LINK 17
`define CMP_COUNT 18

`define MSG_ID_STATUS_REGISTER_ZERO 2'h1
`define MSG_ID_SECOND_STATUS_REGISTER 2'h2
`define CFG_LOST_RST 1'b1

`endif

/* File: rtl/bias_pkg.sv */
// Purpose: Types of the bias supply supervisor.
// Assumes: bias_defs.svh holds the numeric constants.
// Notes: States are one-hot.
package bias_pkg;
`include "bias_defs.svh"

   typedef enum logic [3:0] {
      PWR_SLEEP = 4'h1,
      PWR_STANDBY = 4'h2,
      PWR_RUN = 4'h4,
      PWR_SHUTDOWN = 4'h8
   } pwr_state_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h1,
      TX_LOAD = 3'h2,
      TX_SHIFT = 3'h4
   } tx_state_e;

   typedef logic [`CMP_COUNT-1:0] cmp_vec_t;
endpackage

/* File: rtl/msg_queue.sv */
// Purpose: Small FIFO memory holding outgoing status message bytes.
// Assumes: Read data appear from a register one cycle after rd_en.
// Notes: Writes to a full queue and reads of an empty one are ignored.
`timescale 1ns/10ps
module msg_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Write side.
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic full,
   // Read side.
   input wire logic rd_en,
   output logic [WIDTH-1:0] rd_data,
   output logic empty
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0] count;
      logic [WIDTH-1:0] rdata;
   } queue_s;

   queue_s s_ff;
   queue_s nxt_s;
   logic do_wr;
   logic do_rd;

   function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
      step_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   assign full = (s_ff.count == (PW + 1)'(DEPTH));
   assign empty = (s_ff.count == '0);
   assign rd_data = s_ff.rdata;
   assign do_wr = wr_en && !full;
   assign do_rd = rd_en && !empty;

   always_comb begin
      nxt_s = s_ff;
      if (do_wr) begin
         nxt_s.mem[s_ff.wr_ptr] = wr_data;
         nxt_s.wr_ptr = step_ptr(s_ff.wr_ptr);
      end
      if (do_rd) begin
         nxt_s.rdata = s_ff.mem[s_ff.rd_ptr];
         nxt_s.rd_ptr = step_ptr(s_ff.rd_ptr);
      end
      if (do_wr && !do_rd) begin
         nxt_s.count = s_ff.count + 1'b1;
      end else if (do_rd && !do_wr) begin
         nxt_s.count = s_ff.count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule // msg_queue

/* File: rtl/bias_supply_supervisor.sv */
// Purpose: Enable and supervisory logic of the bias generator with status reporting.
// Assumes: Comparator and pin inputs are asynchronous; sleep and clear requests are on clk_sys.
// Notes: Status bytes leave on the open-drain serial link as 8N1 frames.
`timescale 1ns/10ps
`include "bias_defs.svh"

// Contract
// - 12 V regulator is off whenever chip enable is inactive.
// - 5 V regulator is off in the sleep state.
// - In standby the 5 V regulator state depends on a build parameter.
// - Charge pump runs below the pump start threshold, else 12 V fed directly.
// - Buck overcurrent sets a warning flag and a status report; clears when gone.
// - Buck overcurrent never shuts the buck converter down.
// - Buck output under 90% sets a warning, cleared only at 94%.
// - Buck output under 80% sets lockout fault, reports it, pulls fault pin low.
// - Supply under 4.0 V disables buck, sets lockout fault, reports it.
// - Buck shuts down while supply is above the overvoltage stop threshold.
// - Buck stays off while the feedback pin is held by an external supply.
// - Config lost flag sets at power-up and when supply drops below 3.8 V.
// - Supply under 5.5 V or over 20 V stops motor drivers, bias stays, report; the code also turns the 12 V regulator off under 5.5 V.
// - Supply over 32 V turns every function off.
// - Over-temperature trip turns every function off.
// - After thermal shutdown resume only when cool and chip enable toggled.
// - Thermal warning set point sends a warning message to the host.
// - Messages use a half-duplex 9600 baud, 8 data bit, no parity link.
// - Fault output is held low while any fault is active.
module bias_supply_supervisor #(
   parameter int BIT_CYCLES = `CLK_HZ / `BAUD_RATE,
   parameter int QUEUE_DEPTH = `QUEUE_DEPTH,
   parameter bit STANDBY_5V_ON = 1'b1,
   parameter bit DRIVER_OV20_EN = 1'b1
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Pins and comparator outputs.
   input wire logic chip_enable,
   input wire logic supply_below_pump_start,
   input wire logic supply_below_buck_input_uv,
   input wire logic supply_below_config_lost,
   input wire logic supply_below_driver_uv,
   input wire logic supply_above_driver_ov,
   input wire logic supply_above_system_ov,
   input wire logic supply_above_ov_stop,
   input wire logic buck_input_overcurrent,
   input wire logic buck_output_below_90,
   input wire logic buck_output_at_94,
   input wire logic buck_output_below_80,
   input wire logic buck_feedback_external,
   input wire logic temp_above_shutdown,
   input wire logic temp_below_hysteresis,
   input wire logic temp_above_warning,
   input wire logic motor_current_over_limit,
   // Control from the configuration logic.
   input wire logic sleep_request,
   input wire logic config_lost_clear,
   // Power rail enables and state.
   output logic ldo12_en,
   output logic ldo5_en,
   output logic buck_en,
   output logic pump_en,
   output logic motor_drv_en,
   output bias_pkg::pwr_state_e power_state,
   // Status flags.
   output logic buck_input_overcurrent_warning,
   output logic buck_output_undervoltage_warning,
   output logic buck_undervoltage_lockout_fault,
   output logic config_lost_warning,
   output logic thermal_warning,
   output logic supply_undervoltage_flag,
   output logic supply_overvoltage_flag,
   // Open-drain serial link.
   input wire logic host_serial_link_in,
   output logic host_serial_link_out,
   output logic host_serial_link_oe,
   // Open-drain fault output.
   output logic current_limit_fault_output_out,
   output logic current_limit_fault_output_oe
);
   import bias_pkg::*;

   localparam logic [`BAUD_CNT_W-1:0] BAUD_LAST = `BAUD_CNT_W'(BIT_CYCLES - 1);
   localparam logic [3:0] LAST_BIT = 4'(`FRAME_BITS - 1);

   typedef struct packed {
      cmp_vec_t sync1;
      cmp_vec_t sync2;
      pwr_state_e pwr;
      tx_state_e tx;
      logic otp_latch;
      logic cfg_lost;
      logic ocp_w;
      logic uv_w;
      logic uvlo_f;
      logic therm_w;
      logic vdd_uv;
      logic vdd_ov;
      logic [2:0] prev0;
      logic [3:0] prev1;
      logic pend0;
      logic pend1;
      logic [`BAUD_CNT_W-1:0] baud_cnt;
      logic [3:0] bit_idx;
      logic [`FRAME_BITS-1:0] shreg;
      logic drive_low;
      logic fault_low;
      logic ldo12;
      logic ldo5;
      logic buck;
      logic pump;
      logic motor;
   } state_s;

   state_s s_ff;
   state_s nxt_s;
   cmp_vec_t cmp_raw;
   logic q_wr;
   logic [`MSG_W-1:0] q_wdata;
   logic q_full;
   logic q_rd;
   logic [`MSG_W-1:0] q_rdata;
   logic q_empty;
   logic ce;
   logic ov32;
   logic otp_trip;
   logic buck_in_uv;
   logic all_off;
   logic drv_fault;
   logic buck_allowed;
   logic [2:0] status_register_zero;
   logic [3:0] second_status_register;

   assign cmp_raw[`CMP_PUMP_START] = supply_below_pump_start;
   assign cmp_raw[`CMP_BUCK_IN_UV] = supply_below_buck_input_uv;
   assign cmp_raw[`CMP_CFG_LOST] = supply_below_config_lost;
   assign cmp_raw[`CMP_VDD_UV] = supply_below_driver_uv;
   assign cmp_raw[`CMP_VDD_OV20] = supply_above_driver_ov;
   assign cmp_raw[`CMP_VDD_OV32] = supply_above_system_ov;
   assign cmp_raw[`CMP_OV_STOP] = supply_above_ov_stop;
   assign cmp_raw[`CMP_BUCK_OCP] = buck_input_overcurrent;
   assign cmp_raw[`CMP_BUCK_BELOW90] = buck_output_below_90;
   assign cmp_raw[`CMP_BUCK_AT94] = buck_output_at_94;
   assign cmp_raw[`CMP_BUCK_BELOW80] = buck_output_below_80;
   assign cmp_raw[`CMP_FB_EXT] = buck_feedback_external;
   assign cmp_raw[`CMP_OTP_TRIP] = temp_above_shutdown;
   assign cmp_raw[`CMP_OTP_COOL] = temp_below_hysteresis;
   assign cmp_raw[`CMP_THERM_WARN] = temp_above_warning;
   assign cmp_raw[`CMP_CE] = chip_enable;
   assign cmp_raw[`CMP_ILIM] = motor_current_over_limit;
   assign cmp_raw[`CMP_LINK] = host_serial_link_in;

   // Only the second synchroniser stage feeds the logic below.
   assign ce = s_ff.sync2[`CMP_CE];
   assign ov32 = s_ff.sync2[`CMP_VDD_OV32];
   assign otp_trip = s_ff.sync2[`CMP_OTP_TRIP];
   assign buck_in_uv = s_ff.sync2[`CMP_BUCK_IN_UV];
   assign all_off = s_ff.otp_latch || otp_trip || ov32;
   assign drv_fault = s_ff.sync2[`CMP_VDD_UV] || buck_in_uv || s_ff.sync2[`CMP_BUCK_BELOW80]
                      || (DRIVER_OV20_EN && s_ff.sync2[`CMP_VDD_OV20]);
   assign buck_allowed = !all_off && !(!ce && sleep_request) && !buck_in_uv
                         && !s_ff.sync2[`CMP_OV_STOP] && !s_ff.sync2[`CMP_FB_EXT];
   assign status_register_zero = {s_ff.ocp_w, s_ff.uv_w, s_ff.uvlo_f};
   assign second_status_register = {s_ff.therm_w, s_ff.vdd_uv, s_ff.vdd_ov, s_ff.cfg_lost};

   msg_queue #(
      .WIDTH(`MSG_W),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk_sys(clk_sys),
      .reset(reset),
      .wr_en(q_wr),
      .wr_data(q_wdata),
      .full(q_full),
      .rd_en(q_rd),
      .rd_data(q_rdata),
      .empty(q_empty)
   );

   always_comb begin
      nxt_s = s_ff;
      q_wr = 1'b0;
      q_wdata = '0;
      q_rd = 1'b0;
      nxt_s.sync1 = cmp_raw;
      nxt_s.sync2 = s_ff.sync1;

      // The thermal latch clears only while chip enable is low and the die is cool.
      if (!ce && s_ff.sync2[`CMP_OTP_COOL]) begin
         nxt_s.otp_latch = 1'b0;
      end
      if (otp_trip) begin
         nxt_s.otp_latch = 1'b1;
      end
      if (config_lost_clear) begin
         nxt_s.cfg_lost = 1'b0;
      end
      if (s_ff.sync2[`CMP_CFG_LOST]) begin
         nxt_s.cfg_lost = 1'b1;
      end

      nxt_s.ocp_w = s_ff.sync2[`CMP_BUCK_OCP];
      if (s_ff.sync2[`CMP_BUCK_BELOW90]) begin
         nxt_s.uv_w = 1'b1;
      end else if (s_ff.sync2[`CMP_BUCK_AT94]) begin
         nxt_s.uv_w = 1'b0;
      end
      nxt_s.uvlo_f = s_ff.sync2[`CMP_BUCK_BELOW80] || buck_in_uv;
      nxt_s.therm_w = s_ff.sync2[`CMP_THERM_WARN];
      nxt_s.vdd_uv = s_ff.sync2[`CMP_VDD_UV];
      nxt_s.vdd_ov = (DRIVER_OV20_EN && s_ff.sync2[`CMP_VDD_OV20]) || ov32;

      if (all_off) begin
         nxt_s.pwr = PWR_SHUTDOWN;
      end else if (ce) begin
         nxt_s.pwr = PWR_RUN;
      end else if (sleep_request) begin
         nxt_s.pwr = PWR_SLEEP;
      end else begin
         nxt_s.pwr = PWR_STANDBY;
      end

      case (nxt_s.pwr)
         PWR_RUN: nxt_s.ldo5 = 1'b1;
         PWR_STANDBY: nxt_s.ldo5 = STANDBY_5V_ON;
         default: nxt_s.ldo5 = 1'b0;
      endcase
      nxt_s.buck = buck_allowed;
      nxt_s.ldo12 = (nxt_s.pwr == PWR_RUN) && !s_ff.sync2[`CMP_VDD_UV] && !buck_in_uv;
      nxt_s.pump = nxt_s.ldo12 && s_ff.sync2[`CMP_PUMP_START];
      nxt_s.motor = (nxt_s.pwr == PWR_RUN) && !drv_fault;
      nxt_s.fault_low = all_off || drv_fault || s_ff.sync2[`CMP_ILIM];

      // A push clears a pending report; a fresh change in the same cycle re-arms it.
      if (!q_full && s_ff.pend0) begin
         q_wr = 1'b1;
         q_wdata = {`MSG_ID_STATUS_REGISTER_ZERO, 3'h0, status_register_zero};
         nxt_s.pend0 = 1'b0;
      end else if (!q_full && s_ff.pend1) begin
         q_wr = 1'b1;
         q_wdata = {`MSG_ID_SECOND_STATUS_REGISTER, 2'h0, second_status_register};
         nxt_s.pend1 = 1'b0;
      end
      nxt_s.prev0 = status_register_zero;
      nxt_s.prev1 = second_status_register;
      if (status_register_zero != s_ff.prev0) begin
         nxt_s.pend0 = 1'b1;
      end
      if (second_status_register != s_ff.prev1) begin
         nxt_s.pend1 = 1'b1;
      end

      case (s_ff.tx)
         TX_IDLE: begin
            // Half duplex: wait until the line is released before talking.
            if (!q_empty && s_ff.sync2[`CMP_LINK]) begin
               q_rd = 1'b1;
               nxt_s.tx = TX_LOAD;
            end
         end
         TX_LOAD: begin
            nxt_s.shreg = {1'b1, q_rdata, 1'b0};
            nxt_s.baud_cnt = '0;
            nxt_s.bit_idx = '0;
            nxt_s.tx = TX_SHIFT;
         end
         TX_SHIFT: begin
            if (s_ff.baud_cnt == BAUD_LAST) begin
               nxt_s.baud_cnt = '0;
               nxt_s.shreg = {1'b1, s_ff.shreg[`FRAME_BITS-1:1]};
               if (s_ff.bit_idx == LAST_BIT) begin
                  nxt_s.tx = TX_IDLE;
               end else begin
                  nxt_s.bit_idx = s_ff.bit_idx + 1'b1;
               end
            end else begin
               nxt_s.baud_cnt = s_ff.baud_cnt + 1'b1;
            end
         end
         default: nxt_s.tx = TX_IDLE;
      endcase
      nxt_s.drive_low = (nxt_s.tx == TX_SHIFT) && !nxt_s.shreg[0];
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s_ff <= '0;
         s_ff.cfg_lost <= `CFG_LOST_RST;
         s_ff.pwr <= PWR_STANDBY;
         // Reset parks the block in standby, so the 5 V rail follows the standby variant.
         s_ff.ldo5 <= STANDBY_5V_ON;
         s_ff.tx <= TX_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ldo12_en = s_ff.ldo12;
   assign ldo5_en = s_ff.ldo5;
   assign buck_en = s_ff.buck;
   assign pump_en = s_ff.pump;
   assign motor_drv_en = s_ff.motor;
   assign power_state = s_ff.pwr;
   assign buck_input_overcurrent_warning = s_ff.ocp_w;
   assign buck_output_undervoltage_warning = s_ff.uv_w;
   assign buck_undervoltage_lockout_fault = s_ff.uvlo_f;
   assign config_lost_warning = s_ff.cfg_lost;
   assign thermal_warning = s_ff.therm_w;
   assign supply_undervoltage_flag = s_ff.vdd_uv;
   assign supply_overvoltage_flag = s_ff.vdd_ov;
   assign host_serial_link_out = 1'b0;
   assign host_serial_link_oe = s_ff.drive_low;
   assign current_limit_fault_output_out = 1'b0;
   assign current_limit_fault_output_oe = s_ff.fault_low;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   AST_LDO12_NO_CE: assert property (!ce |=> !ldo12_en)
      else $error("12 V regulator on without chip enable");
   AST_LDO5_SLEEP: assert property (power_state == PWR_SLEEP |-> !ldo5_en)
      else $error("5 V regulator on in sleep");
   AST_LDO5_STANDBY: assert property (power_state == PWR_STANDBY |-> ldo5_en == STANDBY_5V_ON)
      else $error("5 V regulator wrong in standby");
   AST_PUMP: assert property (ldo12_en && !s_ff.sync2[`CMP_PUMP_START] |=> !pump_en)
      else $error("charge pump on above start threshold");
   AST_OCP_KEEPS_BUCK: assert property (s_ff.sync2[`CMP_BUCK_OCP] && !all_off && ce && !buck_in_uv
      && !s_ff.sync2[`CMP_OV_STOP] && !s_ff.sync2[`CMP_FB_EXT] |=> buck_en)
      else $error("buck stopped by overcurrent warning");
   AST_UVW_HOLD: assert property (buck_output_undervoltage_warning && !s_ff.sync2[`CMP_BUCK_AT94]
      |=> buck_output_undervoltage_warning)
      else $error("buck undervoltage warning cleared early");
   AST_UVLO_FAULT: assert property (s_ff.sync2[`CMP_BUCK_BELOW80]
      |=> buck_undervoltage_lockout_fault && current_limit_fault_output_oe && !motor_drv_en)
      else $error("buck brownout not reported");
   AST_BUCK_OFF: assert property (buck_in_uv || s_ff.sync2[`CMP_OV_STOP]
      || s_ff.sync2[`CMP_FB_EXT] |=> !buck_en)
      else $error("buck running under a stop condition");
   AST_CFG_LOST: assert property (s_ff.sync2[`CMP_CFG_LOST] |=> config_lost_warning)
      else $error("config lost flag not set");
   AST_DRV_UV: assert property (s_ff.sync2[`CMP_VDD_UV] |=> !motor_drv_en && supply_undervoltage_flag)
      else $error("motor drivers on under supply undervoltage");
   AST_ALL_OFF: assert property (ov32 || otp_trip
      |=> !ldo12_en && !ldo5_en && !buck_en && !motor_drv_en)
      else $error("function left on in shutdown");
   AST_OTP_LATCH: assert property (s_ff.otp_latch && ce |=> s_ff.otp_latch)
      else $error("thermal latch cleared without chip enable toggle");
   AST_FRAME: assert property (s_ff.tx == TX_LOAD |=> host_serial_link_oe [*8])
      else $error("start bit not driven");
   AST_QUEUE: assert property (status_register_zero != s_ff.prev0 |=> s_ff.pend0 || $past(q_wr))
      else $error("flag change not queued");

   COV_SHUTDOWN: cover property (power_state == PWR_RUN ##1 power_state == PWR_SHUTDOWN);
   COV_FRAME: cover property (s_ff.tx == TX_SHIFT ##1 s_ff.tx == TX_IDLE);
   COV_BOTH_PEND: cover property (s_ff.pend0 && s_ff.pend1);
   COV_STANDBY: cover property (power_state == PWR_STANDBY && buck_en);
endmodule // bias_supply_supervisor

/* File: tb/host_link_model.sv */
// Purpose: Host side of the status link: decodes frames and answers a config lost report.
// Assumes: The line idles high through a pull-up; frames are start, 8 data LSB first, stop.
// Notes: The host never transmits, so it leaves the line released.
`timescale 1ns/10ps
module host_link_model #(
   parameter int BIT_CYCLES = 16
) (
   // Clock.
   input wire logic clk_sys,
   // Line level at the pull-up.
   input wire logic line,
   // Host response and decoded status.
   output logic config_lost_clear,
   output logic [7:0] last_s0,
   output logic [7:0] last_s1,
   output int n_frames,
   output int bad_frames
);
   logic [7:0] rx;

   initial begin
      config_lost_clear = 1'b0;
      last_s0 = 8'h40;
      last_s1 = 8'h80;
      n_frames = 0;
      bad_frames = 0;
      rx = 8'h00;
      forever begin
         @(posedge clk_sys);
         if (line === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYCLES) @(posedge clk_sys);
               rx[i] = line;
            end
            repeat (BIT_CYCLES) @(posedge clk_sys);
            n_frames++;
            if (line !== 1'b1) bad_frames++;
            if (rx[7:6] == 2'b01) last_s0 = rx;
            else if (rx[7:6] == 2'b10) last_s1 = rx;
            else bad_frames++;
            if (rx[7:6] == 2'b10 && rx[0] === 1'b1) begin
               // The host takes note that its settings must be sent again.
               config_lost_clear <= 1'b1;
               @(posedge clk_sys);
               config_lost_clear <= 1'b0;
            end
         end
      end
   end
endmodule // host_link_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench of the bias supply supervisor.
// Assumes: All comparator levels come from one vector driven on the rising edge.
// Notes: Expectations are rebuilt from that vector and two states held by the bench.
`timescale 1ns/10ps
`include "bias_defs.svh"
module tb;
   import bias_pkg::*;
   localparam int BITC = 16;
   localparam int PS = `CMP_PUMP_START, BUV = `CMP_BUCK_IN_UV, CFG = `CMP_CFG_LOST;
   localparam int UV = `CMP_VDD_UV, OV20 = `CMP_VDD_OV20, OV32 = `CMP_VDD_OV32;
   localparam int OVS = `CMP_OV_STOP, OCP = `CMP_BUCK_OCP, B90 = `CMP_BUCK_BELOW90;
   localparam int A94 = `CMP_BUCK_AT94, B80 = `CMP_BUCK_BELOW80, FBX = `CMP_FB_EXT;
   localparam int TRIP = `CMP_OTP_TRIP, COOL = `CMP_OTP_COOL, WARN = `CMP_THERM_WARN;
   localparam int CE = `CMP_CE, ILIM = `CMP_ILIM, SLP = 17;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [17:0] iv = 18'h00000;
   logic ldo12_en, ldo5_en, buck_en, pump_en, motor_drv_en;
   pwr_state_e power_state;
   logic ocp_w, uv_w, uvlo_f, cfg_w, therm_w, suv_f, sov_f;
   logic link_out, link_oe, fault_out, fault_oe, cfg_clr, line;
   logic [7:0] last_s0, last_s1;
   int n_frames, bad_frames;
   int error_cnt = 0;
   int n_checks = 0;
   logic otp_m = 1'b0;
   logic uvw_m = 1'b0;

   // Open-drain link with a pull-up; the host only listens.
   assign line = (link_oe === 1'b1) ? 1'b0 : 1'b1;

   bias_supply_supervisor #(.BIT_CYCLES(BITC)) dut (
      .clk_sys(clk_sys), .reset(reset), .chip_enable(iv[CE]),
      .supply_below_pump_start(iv[PS]), .supply_below_buck_input_uv(iv[BUV]),
      .supply_below_config_lost(iv[CFG]), .supply_below_driver_uv(iv[UV]),
      .supply_above_driver_ov(iv[OV20]), .supply_above_system_ov(iv[OV32]),
      .supply_above_ov_stop(iv[OVS]), .buck_input_overcurrent(iv[OCP]),
      .buck_output_below_90(iv[B90]), .buck_output_at_94(iv[A94]),
      .buck_output_below_80(iv[B80]), .buck_feedback_external(iv[FBX]),
      .temp_above_shutdown(iv[TRIP]), .temp_below_hysteresis(iv[COOL]),
      .temp_above_warning(iv[WARN]), .motor_current_over_limit(iv[ILIM]),
      .sleep_request(iv[SLP]), .config_lost_clear(cfg_clr), .ldo12_en(ldo12_en),
      .ldo5_en(ldo5_en), .buck_en(buck_en), .pump_en(pump_en), .motor_drv_en(motor_drv_en),
      .power_state(power_state), .buck_input_overcurrent_warning(ocp_w),
      .buck_output_undervoltage_warning(uv_w), .buck_undervoltage_lockout_fault(uvlo_f),
      .config_lost_warning(cfg_w), .thermal_warning(therm_w),
      .supply_undervoltage_flag(suv_f), .supply_overvoltage_flag(sov_f),
      .host_serial_link_in(line), .host_serial_link_out(link_out),
      .host_serial_link_oe(link_oe), .current_limit_fault_output_out(fault_out),
      .current_limit_fault_output_oe(fault_oe));

   host_link_model #(.BIT_CYCLES(BITC)) host (.clk_sys(clk_sys), .line(line),
      .config_lost_clear(cfg_clr), .last_s0(last_s0), .last_s1(last_s1),
      .n_frames(n_frames), .bad_frames(bad_frames));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [17:0] m(input int a);
      return 18'h00001 << a;
   endfunction

   task automatic cmp_bit(input string name, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0b, seen %0b", name, exp, got);
      end
   endtask

   task automatic cmp_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Applies a vector, lets it cross the synchroniser, then updates the bench states.
   task automatic apply(input logic [17:0] v);
      @(posedge clk_sys) iv <= v;
      repeat (4) @(posedge clk_sys);
      #1;
      if (v[TRIP]) otp_m = 1'b1;
      else if (!v[CE] && v[COOL]) otp_m = 1'b0;
      if (v[B90]) uvw_m = 1'b1;
      else if (v[A94]) uvw_m = 1'b0;
   endtask

   task automatic check_all(input logic [17:0] v);
      logic sd, run, slp, drv, uv4;
      pwr_state_e ps;
      sd = otp_m | v[TRIP] | v[OV32];
      run = !sd & v[CE];
      slp = !sd & !run & v[SLP];
      ps = sd ? PWR_SHUTDOWN : run ? PWR_RUN : slp ? PWR_SLEEP : PWR_STANDBY;
      uv4 = v[BUV];
      drv = v[UV] | uv4 | v[B80] | v[OV20];
      cmp_vec("power_state", {4'h0, ps}, {4'h0, power_state});
      cmp_bit("ldo12_en", run & !v[UV] & !uv4, ldo12_en);
      cmp_bit("ldo5_en", run | (ps == PWR_STANDBY), ldo5_en);
      cmp_bit("pump_en", run & !v[UV] & !uv4 & v[PS], pump_en);
      cmp_bit("buck_en", !sd & !slp & !uv4 & !v[OVS] & !v[FBX], buck_en);
      cmp_bit("motor_drv_en", run & !drv, motor_drv_en);
      cmp_bit("fault_oe", sd | drv | v[ILIM], fault_oe);
      cmp_bit("ocp_warning", v[OCP], ocp_w);
      cmp_bit("uv_warning", uvw_m, uv_w);
      cmp_bit("uvlo_fault", v[B80] | uv4, uvlo_f);
      cmp_bit("thermal_warning", v[WARN], therm_w);
      if (v[CFG]) cmp_bit("config_lost", 1'b1, cfg_w);
      cmp_bit("supply_uv_flag", v[UV], suv_f);
      cmp_bit("supply_ov_flag", v[OV20] | v[OV32], sov_f);
      cmp_bit("link_out", 1'b0, link_out);
      cmp_bit("fault_out", 1'b0, fault_out);
   endtask

   // Waits until the link has gone quiet, then compares the last reports.
   task automatic check_msgs(input logic [17:0] v);
      int quiet;
      quiet = 0;
      for (int i = 0; i < 6000 && quiet < 30 * BITC; i++) begin
         @(posedge clk_sys);
         quiet = (link_oe === 1'b0) ? quiet + 1 : 0;
      end
      cmp_bit("link_quiet", 1'b1, quiet >= 30 * BITC);
      cmp_vec("status0", {5'h08, v[OCP], uvw_m, v[B80] | v[BUV]}, last_s0);
      cmp_vec("status1", {5'h00, 2'b10, v[WARN]}, {5'h00, last_s1[7:6], last_s1[3]});
   endtask

   initial begin
      logic [17:0] dir [16];
      logic [17:0] v;
      dir = '{18'h00000, m(CE), m(CE) | m(PS), m(CE) | m(B90), m(CE), m(CE) | m(A94),
         m(CE) | m(OCP), m(CE) | m(TRIP), m(CE) | m(COOL), m(COOL), m(CE),
         m(CE) | m(WARN), m(CE), m(SLP), m(CE) | m(OV32), m(CE) | m(FBX) | m(CFG)};
      void'($urandom(27));
      repeat (3) @(posedge clk_sys);
      #1 cmp_vec("reset_state", {4'h0, PWR_STANDBY}, {4'h0, power_state});
      cmp_bit("reset_config_lost", 1'b1, cfg_w);
      cmp_bit("reset_buck_en", 1'b0, buck_en);
      @(posedge clk_sys) reset <= 1'b0;
      // The thermal trip is followed by the part cooling off, first with chip enable high, then low, then enabled again.
      foreach (dir[i]) begin
         apply(dir[i]);
         check_all(dir[i]);
         check_msgs(dir[i]);
      end
      apply(m(CE));
      @(posedge clk_sys) iv <= m(CE) | m(UV);
      repeat (2) @(posedge clk_sys);
      #1 cmp_bit("motor_drv_en_early", 1'b1, motor_drv_en);
      @(posedge clk_sys);
      #1 cmp_bit("motor_drv_en_late", 1'b0, motor_drv_en);
      for (int n = 0; n < 40; n++) begin
         v = 18'($urandom & $urandom);
         v[CE] = ($urandom_range(0, 3) != 0);
         apply(v);
         check_all(v);
         check_msgs(v);
      end
      cmp_bit("frames_seen", 1'b1, n_frames > 0);
      cmp_vec("bad_frames", 8'h00, 8'(bad_frames));
      final_report();
   end

   initial begin
      #950000;
      error_cnt++;
      $display("unexpected watchdog: expected done, seen timeout");
      final_report();
   end
endmodule // tb
